// ===== design/position_pulse_monitor_select.sv
// Overview of operation
// RL1 - digit 0 or 1 shows low or high word of the command count.
// RL2 - digit 2 or 3 shows low or high word of the feedback count.
// RL3 - digit 4 or 5 shows low or high word of the droop count.
// RL4 - hundreds digit: 0 after gear, 1 before gear, for the pulse monitor.
// RL5 - thousands digit: 0 before gear, 1 after gear, for multifunction monitors.
// RL6 - main select zero shows output frequency on the panel; the code does so only with pulse select 8888/9999 or item digit above 5.
// RL7 - codes 26 to 31 show pulse words with the switched gear treatment.
// RL8 - position, feedback and droop counters count from servo on.
// RL9 - pulse counters wrap freely past the eight-digit maximum.
// RL10 - codes 71 and 72 route cumulative value and overflow count.
// RL11 - cumulative value and overflow stay within -32767 to 32767.
// RL12 - four-digit panel shows dashes above 9999.
// RL13 - negative cumulative values stay negative; basic panel hides negatives.
// RL14 - LCD shows -1..-32767 as 65535..32769.
// RL15 - total equals factor times overflow times 32768 plus value.
// RL16 - clear mode 0 clears on rising edge, mode 1 while input high.
// RL17 - low word holds four low decimal digits, high word the rest.
// Purpose: pulse monitor selection and cumulative encoder pulse monitor
// Assumes: deltas arrive once per cycle, synchronous inputs
// Notes:   panel main select 0 with pulse select 8888/9999 shows frequency
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module position_pulse_monitor_select #(
   parameter int N_MON = 4
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // register port
   input  wire logic [3:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_write,
   input  wire logic               reg_read,
   output logic      [31:0]        reg_rdata,
   // position loop, index gear*3+item, gear 1 after gear
   input  wire logic               servo_on,
   input  wire logic [5:0][15:0]   pulse_delta,
   input  wire logic [15:0]        out_freq,
   // encoder and clear
   input  wire logic               enc_inc,
   input  wire logic               enc_dec,
   input  wire logic               cumulative_clear_input,
   // monitor outputs
   output logic      [15:0]        panel_value,
   output logic                    panel_dash,
   output logic      [15:0]        lcd_value,
   output logic [N_MON-1:0][31:0]  mon_value,
   output logic      [15:0]        cum_value,
   output logic      [15:0]        cum_overflow
);
   if (N_MON != 4) begin : g_chk
      $error("three aux selects and one extra select are served");
   end

   // settings and state
   logic [13:0]             pulse_monitor_select;
   logic [7:0]              main_monitor_select;
   logic [N_MON-1:0][7:0]   mon_sel;
   logic                    minus_sign_display_select;
   logic                    cumulative_clear_mode;
   logic [14:0]             cumulative_division_factor;
   logic [5:0][31:0]        cnt;
   logic signed [15:0]      div_cnt;
   logic                    clr_d;

   function automatic logic [3:0] dec_digit(input logic [13:0] v, input logic [1:0] pos);
      logic [13:0] d;
      d = 14'h0001;
      case (pos)
         2'd1:    d = 14'h000A;
         2'd2:    d = 14'h0064;
         2'd3:    d = 14'h03E8;
         default: d = 14'h0001;
      endcase
      return 4'((v / d) % 14'h000A);
   endfunction

   function automatic logic [3:0] word_index(input logic [3:0] item, input logic gear);
      return 4'({3'b000, gear} * 4'h6 + item);
   endfunction

   // register writes
   wire logic wr_pulse = reg_write && reg_addr == pulse_monitor_pkg::OFS_PULSE_SEL;
   wire logic wr_main  = reg_write && reg_addr == pulse_monitor_pkg::OFS_MAIN_SEL;
   wire logic wr_sign  = reg_write && reg_addr == pulse_monitor_pkg::OFS_SIGN_SEL;
   wire logic wr_mode  = reg_write && reg_addr == pulse_monitor_pkg::OFS_CLR_MODE;
   wire logic wr_div   = reg_write && reg_addr == pulse_monitor_pkg::OFS_DIV_FACTOR
                         && reg_wdata[14:0] != 15'h0000
                         && reg_wdata[14:0] <= pulse_monitor_pkg::DIV_FACTOR_MAX
                         && reg_wdata[31:15] == 17'h0_0000;
   wire logic pulse_ok = reg_wdata[13:0] <= pulse_monitor_pkg::SEL_FREQ_B
                         && reg_wdata[31:14] == 18'h0_0000;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pulse_monitor_select       <= pulse_monitor_pkg::RST_PULSE_SEL;
         main_monitor_select        <= pulse_monitor_pkg::RST_MON_SEL;
         minus_sign_display_select  <= 1'b0;
         cumulative_clear_mode      <= 1'b0;
         cumulative_division_factor <= pulse_monitor_pkg::RST_DIV_FACTOR;
      end else begin
         if (wr_pulse && pulse_ok) pulse_monitor_select <= reg_wdata[13:0];
         if (wr_main) main_monitor_select <= reg_wdata[7:0];
         if (wr_sign) minus_sign_display_select <= reg_wdata[0];
         if (wr_mode) cumulative_clear_mode <= reg_wdata[0];
         if (wr_div) cumulative_division_factor <= reg_wdata[14:0];
      end
   end

   for (genvar m = 0; m < N_MON; m++) begin : g_sel
      wire logic wr_m = reg_write && reg_addr == 4'(pulse_monitor_pkg::OFS_AUX0_SEL + 4'(m));
      always_ff @(posedge sys_clk) begin
         if (rst) mon_sel[m] <= pulse_monitor_pkg::RST_MON_SEL;
         else if (wr_m) mon_sel[m] <= reg_wdata[7:0];
      end
   end

   // position counters and decimal split
   split_if sp[6] ();
   logic [11:0][15:0] words;

   for (genvar c = 0; c < 6; c++) begin : g_cnt
      always_ff @(posedge sys_clk) begin
         // RL8 count from servo on
         if (rst || !servo_on) cnt[c] <= 32'h0000_0000;
         // RL9 free running wrap
         else cnt[c] <= 32'(cnt[c] + {{16{pulse_delta[c][15]}}, pulse_delta[c]});
      end
      assign sp[c].count = cnt[c];
      assign words[2*c]   = sp[c].lower;
      assign words[2*c+1] = sp[c].upper;
      decimal_split #(.WIDTH(32)) u_split (
         .sys_clk (sys_clk),
         .rst     (rst),
         .port    (sp[c])
      );
   end

   // cumulative encoder pulse monitor
   wire logic        clr_edge  = cumulative_clear_input && !clr_d;
   // RL16 edge or level clear
   wire logic        cum_clear = cumulative_clear_mode ? cumulative_clear_input : clr_edge;
   wire logic        dir_up    = enc_inc && !enc_dec;
   wire logic        dir_dn    = enc_dec && !enc_inc;
   wire logic signed [15:0] fac = signed'({1'b0, cumulative_division_factor});
   wire logic        step_up   = dir_up && 16'(div_cnt + 16'sd1) == fac;
   wire logic        step_dn   = dir_dn && 16'(div_cnt - 16'sd1) == 16'(-fac);
   wire logic        cum_top   = cum_value == pulse_monitor_pkg::CUM_MAX;
   wire logic        cum_bot   = cum_value == pulse_monitor_pkg::CUM_MIN;
   wire logic        ovf_top   = cum_overflow == pulse_monitor_pkg::CUM_MAX;
   wire logic        ovf_bot   = cum_overflow == pulse_monitor_pkg::CUM_MIN;

   // RL15 factor prescale, overflow every 32768
   wire logic [15:0] next_div  = (step_up || step_dn) ? 16'h0000 :
                                 dir_up ? 16'(div_cnt + 16'sd1) :
                                 dir_dn ? 16'(div_cnt - 16'sd1) : div_cnt;
   // RL11 value wraps to zero past the range
   wire logic [15:0] next_cum  = (step_up && cum_top) || (step_dn && cum_bot) ? 16'h0000 :
                                 step_up ? 16'(cum_value + 16'h0001) :
                                 step_dn ? 16'(cum_value - 16'h0001) : cum_value;
   wire logic [15:0] next_ovf  = (step_up && cum_top) ?
                                 (ovf_top ? 16'h0000 : 16'(cum_overflow + 16'h0001)) :
                                 (step_dn && cum_bot) ?
                                 (ovf_bot ? 16'h0000 : 16'(cum_overflow - 16'h0001)) :
                                 cum_overflow;

   always_ff @(posedge sys_clk) begin
      if (rst) clr_d <= 1'b0;
      else clr_d <= cumulative_clear_input;
   end

   always_ff @(posedge sys_clk) begin
      if (rst || cum_clear) begin
         div_cnt      <= 16'sd0;
         cum_value    <= 16'h0000;
         cum_overflow <= 16'h0000;
      end else begin
         div_cnt      <= signed'(next_div);
         cum_value    <= next_cum;
         cum_overflow <= next_ovf;
      end
   end

   // selection of monitor words
   wire logic [3:0]  item      = dec_digit(pulse_monitor_select, 2'd0);
   wire logic [3:0]  hund      = dec_digit(pulse_monitor_select, 2'd2);
   wire logic [3:0]  thou      = dec_digit(pulse_monitor_select, 2'd3);
   wire logic        freq_mode = pulse_monitor_select == pulse_monitor_pkg::SEL_FREQ_A
                                 || pulse_monitor_select == pulse_monitor_pkg::SEL_FREQ_B
                                 || item > pulse_monitor_pkg::ITEM_LAST;
   // RL4 hundreds digit, 0 after gear
   wire logic        pm_gear   = hund == 4'h0;
   // RL5 thousands digit, 1 after gear
   wire logic        mf_gear   = thou == 4'h1;
   wire logic [15:0] freq_mag  = out_freq[15] ? 16'(-out_freq) : out_freq;
   wire logic [31:0] freq_word = minus_sign_display_select ? {{16{out_freq[15]}}, out_freq}
                                                           : {16'h0000, freq_mag};
   // RL13 cumulative always signed
   wire logic [31:0] cum_word  = {{16{cum_value[15]}}, cum_value};
   wire logic [31:0] ovf_word  = {{16{cum_overflow[15]}}, cum_overflow};

   function automatic logic [31:0] route(input logic [7:0] code, input logic [11:0][15:0] w,
                                         input logic gear, input logic [31:0] fw,
                                         input logic [31:0] cw, input logic [31:0] ow);
      logic [7:0] k;
      k = 8'(code - pulse_monitor_pkg::CODE_GEAR_LO);
      // RL10 cumulative codes
      if (code == pulse_monitor_pkg::CODE_CUM_VALUE) return cw;
      if (code == pulse_monitor_pkg::CODE_CUM_OVF) return ow;
      // RL7 gear switched pulse words
      if (code >= pulse_monitor_pkg::CODE_GEAR_LO && code <= pulse_monitor_pkg::CODE_GEAR_HI)
         return {16'h0000, w[word_index(k[3:0], gear)]};
      return fw;
   endfunction

   // RL1 RL2 RL3 item digit picks word
   wire logic [31:0] pm_word   = {16'h0000, words[word_index(item, pm_gear)]};
   // RL6 main select zero
   wire logic [31:0] panel_src = main_monitor_select == pulse_monitor_pkg::CODE_FREQ ?
                                 (freq_mode ? freq_word : pm_word) :
                                 route(main_monitor_select, words, mf_gear,
                                       freq_word, cum_word, ovf_word);
   // RL12 RL13 dash above 9999 or negative
   wire logic        next_dash = panel_src[31] || panel_src > pulse_monitor_pkg::PANEL_MAX;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         panel_value <= 16'h0000;
         panel_dash  <= 1'b0;
         lcd_value   <= 16'h0000;
      end else begin
         panel_value <= next_dash ? 16'h0000 : panel_src[15:0];
         panel_dash  <= next_dash;
         // RL14 two's complement on LCD
         lcd_value   <= panel_src[15:0];
      end
   end

   for (genvar m = 0; m < N_MON; m++) begin : g_mon
      wire logic [31:0] next_mon = route(mon_sel[m], words, mf_gear,
                                         freq_word, cum_word, ovf_word);
      always_ff @(posedge sys_clk) begin
         if (rst) mon_value[m] <= 32'h0000_0000;
         else mon_value[m] <= next_mon;
      end
   end

   // read back
   wire logic [31:0] rd_mux =
      reg_addr == pulse_monitor_pkg::OFS_PULSE_SEL  ? {18'h0_0000, pulse_monitor_select} :
      reg_addr == pulse_monitor_pkg::OFS_MAIN_SEL   ? {24'h00_0000, main_monitor_select} :
      reg_addr == pulse_monitor_pkg::OFS_AUX0_SEL   ? {24'h00_0000, mon_sel[0]} :
      reg_addr == pulse_monitor_pkg::OFS_AUX1_SEL   ? {24'h00_0000, mon_sel[1]} :
      reg_addr == pulse_monitor_pkg::OFS_AUX2_SEL   ? {24'h00_0000, mon_sel[2]} :
      reg_addr == pulse_monitor_pkg::OFS_EXTRA_SEL  ? {24'h00_0000, mon_sel[3]} :
      reg_addr == pulse_monitor_pkg::OFS_SIGN_SEL   ? {31'h0000_0000, minus_sign_display_select} :
      reg_addr == pulse_monitor_pkg::OFS_CLR_MODE   ? {31'h0000_0000, cumulative_clear_mode} :
      reg_addr == pulse_monitor_pkg::OFS_DIV_FACTOR ? {17'h0_0000, cumulative_division_factor} :
      reg_addr == pulse_monitor_pkg::OFS_CUM_VALUE  ? cum_word :
      reg_addr == pulse_monitor_pkg::OFS_CUM_OVF    ? ovf_word : 32'h0000_0000;

   always_ff @(posedge sys_clk) begin
      if (rst) reg_rdata <= 32'h0000_0000;
      else reg_rdata <= reg_read ? rd_mux : 32'h0000_0000;
   end

   // checks
   a_servo_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL8
      !servo_on |=> cnt[0] == 32'h0000_0000 && cnt[5] == 32'h0000_0000)
      else $error("counter not held at zero while servo off");
   a_count_wrap: assert property (@(posedge sys_clk) disable iff (rst) // RL9
      servo_on && cnt[0] == 32'hFFFF_FFFF && pulse_delta[0] == 16'h0001
      |=> cnt[0] == 32'h0000_0000)
      else $error("pulse counter did not wrap");
   a_cum_range: assert property (@(posedge sys_clk) disable iff (rst) // RL11
      cum_value != 16'h8000 && cum_overflow != 16'h8000)
      else $error("cumulative value outside range");
   a_cum_overflow: assert property (@(posedge sys_clk) disable iff (rst) // RL15
      step_up && cum_top && !ovf_top && !cum_clear
      |=> cum_value == 16'h0000 && cum_overflow == 16'($past(cum_overflow) + 16'h0001))
      else $error("overflow step wrong");
   a_prescale_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL15
      dir_up && !step_up && !cum_clear |=> $stable(cum_value))
      else $error("value stepped before factor reached");
   a_clear_level: assert property (@(posedge sys_clk) disable iff (rst) // RL16
      cumulative_clear_mode && cumulative_clear_input ##1 cumulative_clear_input
      |=> cum_value == 16'h0000 && cum_overflow == 16'h0000)
      else $error("level clear not held");
   a_clear_edge: assert property (@(posedge sys_clk) disable iff (rst) // RL16
      !cumulative_clear_mode && $rose(cumulative_clear_input) |=> cum_value == 16'h0000)
      else $error("edge clear missed");
   a_panel_dash: assert property (@(posedge sys_clk) disable iff (rst) // RL12
      panel_src > pulse_monitor_pkg::PANEL_MAX |=> panel_dash && panel_value == 16'h0000)
      else $error("dash missing above 9999");
   a_lcd_twos: assert property (@(posedge sys_clk) disable iff (rst) // RL14
      main_monitor_select == pulse_monitor_pkg::CODE_CUM_VALUE |=> lcd_value == $past(cum_value))
      else $error("lcd value not two's complement");
   a_mon_cum: assert property (@(posedge sys_clk) disable iff (rst) // RL10
      mon_sel[0] == pulse_monitor_pkg::CODE_CUM_OVF |=> mon_value[0] == $past(ovf_word))
      else $error("overflow count not routed");
   a_freq_main: assert property (@(posedge sys_clk) disable iff (rst) // RL6
      main_monitor_select == pulse_monitor_pkg::CODE_FREQ && freq_mode && !freq_word[31]
      && freq_word <= pulse_monitor_pkg::PANEL_MAX |=> panel_value == $past(freq_word[15:0]))
      else $error("frequency not shown");
   a_pm_before: assert property (@(posedge sys_clk) disable iff (rst) // RL4
      main_monitor_select == pulse_monitor_pkg::CODE_FREQ && !freq_mode
      && item == 4'h0 && hund == 4'h1 |=> panel_value == $past(words[0]))
      else $error("pulse monitor gear wrong");
   a_item_droop: assert property (@(posedge sys_clk) disable iff (rst) // RL3
      main_monitor_select == pulse_monitor_pkg::CODE_FREQ && !freq_mode
      && item == 4'h5 && pm_gear |=> panel_value == $past(words[11]))
      else $error("droop upper word not shown");
   a_mf_after: assert property (@(posedge sys_clk) disable iff (rst) // RL5
      mon_sel[0] == pulse_monitor_pkg::CODE_GEAR_LO && thou == 4'h1
      |=> mon_value[0] == {16'h0000, $past(words[6])})
      else $error("monitor gear wrong");
   a_gear_feed: assert property (@(posedge sys_clk) disable iff (rst) // RL2
      mon_sel[0] == 8'(pulse_monitor_pkg::CODE_GEAR_LO + 8'h02) && !mf_gear
      |=> mon_value[0] == {16'h0000, $past(words[2])})
      else $error("feedback lower word not routed");
   a_panel_neg: assert property (@(posedge sys_clk) disable iff (rst) // RL13
      panel_src[31] |=> panel_dash && panel_value == 16'h0000)
      else $error("negative value shown on panel");
   a_cum_down: assert property (@(posedge sys_clk) disable iff (rst) // RL15
      step_dn && !cum_bot && !cum_clear |=> cum_value == 16'($past(cum_value) - 16'h0001))
      else $error("down step wrong");
   a_edge_level: assert property (@(posedge sys_clk) disable iff (rst) // RL16
      !cumulative_clear_mode && cumulative_clear_input && clr_d && step_up && !cum_top
      |=> cum_value == 16'($past(cum_value) + 16'h0001))
      else $error("edge mode cleared on level");
   a_lcd_neg: assert property (@(posedge sys_clk) disable iff (rst) // RL14
      main_monitor_select == pulse_monitor_pkg::CODE_CUM_VALUE && cum_value[15]
      |=> lcd_value[15] && panel_dash)
      else $error("negative cumulative not shown");
   a_mon_value: assert property (@(posedge sys_clk) disable iff (rst) // RL10
      mon_sel[1] == pulse_monitor_pkg::CODE_CUM_VALUE |=> mon_value[1] == $past(cum_word))
      else $error("cumulative value not routed");
   c_overflow: cover property (@(posedge sys_clk) disable iff (rst) step_up && cum_top);
   c_edge_clear: cover property (@(posedge sys_clk) disable iff (rst)
      clr_edge && !cumulative_clear_mode);
   c_dash: cover property (@(posedge sys_clk) disable iff (rst) panel_dash);
   c_pulse_panel: cover property (@(posedge sys_clk) disable iff (rst)
      main_monitor_select == pulse_monitor_pkg::CODE_FREQ && !freq_mode && servo_on);
endmodule

// ===== design/pulse_monitor_pkg.sv
// Purpose: shared constants for the pulse monitor selection block
// Assumes: word addressed register port, 32-bit data
// Notes:   all codes and limits are held here once
package pulse_monitor_pkg;
   // register indexes on the plain register port
   localparam logic [3:0]  OFS_PULSE_SEL   = 4'h0;
   localparam logic [3:0]  OFS_MAIN_SEL    = 4'h1;
   localparam logic [3:0]  OFS_AUX0_SEL    = 4'h2;
   localparam logic [3:0]  OFS_AUX1_SEL    = 4'h3;
   localparam logic [3:0]  OFS_AUX2_SEL    = 4'h4;
   localparam logic [3:0]  OFS_EXTRA_SEL   = 4'h5;
   localparam logic [3:0]  OFS_SIGN_SEL    = 4'h6;
   localparam logic [3:0]  OFS_CLR_MODE    = 4'h7;
   localparam logic [3:0]  OFS_DIV_FACTOR  = 4'h8;
   localparam logic [3:0]  OFS_CUM_VALUE   = 4'h9;
   localparam logic [3:0]  OFS_CUM_OVF     = 4'hA;
   // reset values
   localparam logic [13:0] RST_PULSE_SEL   = 14'h270F;
   localparam logic [7:0]  RST_MON_SEL     = 8'h00;
   localparam logic [14:0] RST_DIV_FACTOR  = 15'h0001;
   // limits and codes
   localparam logic [14:0] DIV_FACTOR_MAX  = 15'h4000;
   localparam logic [13:0] SEL_FREQ_A      = 14'h22B8;
   localparam logic [13:0] SEL_FREQ_B      = 14'h270F;
   localparam logic [7:0]  CODE_FREQ       = 8'h00;
   localparam logic [7:0]  CODE_GEAR_LO    = 8'h1A;
   localparam logic [7:0]  CODE_GEAR_HI    = 8'h1F;
   localparam logic [7:0]  CODE_CUM_VALUE  = 8'h47;
   localparam logic [7:0]  CODE_CUM_OVF    = 8'h48;
   localparam logic [15:0] CUM_MAX         = 16'h7FFF;
   localparam logic [15:0] CUM_MIN         = 16'h8001;
   localparam logic [31:0] PANEL_MAX       = 32'h0000_270F;
   localparam logic [31:0] DEC_SPLIT       = 32'h0000_2710;
   localparam logic [3:0]  ITEM_LAST       = 4'h5;
endpackage

// ===== design/split_if.sv
// Purpose: carries one count and its two decimal display words
// Assumes: one clock domain
// Notes:   splitter answers one cycle after the count
`timescale 1ns/1ps
interface split_if;
   logic [31:0] count;
   logic [15:0] lower;
   logic [15:0] upper;
   modport splitter (input count, output lower, output upper);
   modport user     (output count, input lower, input upper);
endinterface

// ===== design/decimal_split.sv
// Purpose: splits a count into low four and next four decimal digits
// Assumes: count is two's complement, magnitude is shown
// Notes:   registered, one cycle latency
`timescale 1ns/1ps
module decimal_split #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst,
   // count and words
   split_if.splitter     port
);
   if (WIDTH != 32) begin : g_chk
      $error("decimal_split supports a 32-bit count only");
   end

   wire logic [31:0] mag = port.count[31] ? 32'(-port.count) : port.count;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         port.lower <= 16'h0000;
         port.upper <= 16'h0000;
      end else begin
         // RL17 low and high digits
         port.lower <= 16'(mag % pulse_monitor_pkg::DEC_SPLIT);
         port.upper <= 16'((mag / pulse_monitor_pkg::DEC_SPLIT) % pulse_monitor_pkg::DEC_SPLIT);
      end
   end
endmodule

// ===== dv/panel_display_model.sv
// Purpose: operator panel and monitor reader model on the far side
// Assumes: panel outputs settle one cycle before the reader looks
// Notes:   dash pattern is shown as the code DASH_CODE
`timescale 1ns/1ps
module panel_display_model #(
   parameter logic [15:0] DASH_CODE = 16'hDDDD
) (
   // clock
   input  wire logic        sys_clk,
   // from the block
   input  wire logic [15:0] panel_value,
   input  wire logic        panel_dash,
   input  wire logic [15:0] lcd_value,
   // what the reader sees
   output logic      [15:0] panel_shown,
   output logic      [15:0] lcd_shown
);
   always_ff @(posedge sys_clk) begin
      panel_shown <= panel_dash ? DASH_CODE : panel_value;
      lcd_shown   <= lcd_value;
   end
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for the pulse monitor selection block
// Assumes: word addressed register port, one clock
// Notes:   panel values are read through the display model
`timescale 1ns/1ps
module tb;
   logic             sys_clk = 1'b0;
   logic             rst = 1'b1;
   logic [3:0]       reg_addr = 4'h0;
   logic [31:0]      reg_wdata = 32'h0000_0000;
   logic             reg_write = 1'b0;
   logic             reg_read = 1'b0;
   logic [31:0]      reg_rdata;
   logic             servo_on = 1'b0;
   logic [5:0][15:0] pulse_delta = '0;
   logic [15:0]      out_freq = 16'h0000;
   logic             enc_inc = 1'b0;
   logic             enc_dec = 1'b0;
   logic             cumulative_clear_input = 1'b0;
   logic [15:0]      panel_value, lcd_value, cum_value, cum_overflow;
   logic             panel_dash;
   logic [3:0][31:0] mon_value;
   logic [15:0]      panel_shown, lcd_shown;
   logic [15:0]      expw [12];
   logic [31:0]      rd;
   int               err_total = 0;
   int               tests_run = 0;
   int               cycles = 0;

   position_pulse_monitor_select #(.N_MON(4)) dut (.sys_clk(sys_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .servo_on(servo_on),
      .pulse_delta(pulse_delta), .out_freq(out_freq), .enc_inc(enc_inc),
      .enc_dec(enc_dec), .cumulative_clear_input(cumulative_clear_input),
      .panel_value(panel_value), .panel_dash(panel_dash), .lcd_value(lcd_value),
      .mon_value(mon_value), .cum_value(cum_value), .cum_overflow(cum_overflow));
   panel_display_model panel_model (.sys_clk(sys_clk), .panel_value(panel_value),
      .panel_dash(panel_dash), .lcd_value(lcd_value), .panel_shown(panel_shown),
      .lcd_shown(lcd_shown));

   always #5 sys_clk = ~sys_clk;

   task automatic give_verdict();
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 45000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask
   // n encoder counts up or down, one per cycle
   task automatic pulses(input logic up, input int n);
      @(posedge sys_clk);
      enc_inc <= up;
      enc_dec <= ~up;
      tick(n);
      enc_inc <= 1'b0;
      enc_dec <= 1'b0;
   endtask

   initial begin
      expw = '{16'h0924, 16'h0001, 16'h0032, 16'h0000, 16'h0014, 16'h0000,
               16'h0000, 16'h0002, 16'h000A, 16'h0001, 16'h005A, 16'h0000};
      tick(8);
      rst <= 1'b0;
      rdr(4'h0, rd);
      chk32(rd, 32'h0000_270F);
      wr(4'h0, 32'h0000_0064);
      pulse_delta <= {16'h0009, 16'h03E9, 16'h07D0, 16'h0002, 16'h0005, 16'h04D2};
      tick(5);
      chk16(panel_shown, 16'h0000);
      servo_on <= 1'b1;
      tick(10);
      pulse_delta <= '0;
      tick(4);
      // every item, half, panel gear and monitor gear
      for (int t = 0; t < 2; t++) begin
         for (int h = 0; h < 2; h++) begin
            for (int d = 0; d < 6; d++) begin
               wr(4'h0, 32'(t * 1000 + h * 100 + d));
               wr(4'h2, 32'(pulse_monitor_pkg::CODE_GEAR_LO + 8'(d)));
               tick(4);
               chk16(panel_shown, expw[(1 - h) * 6 + d]);
               chk32(mon_value[0], {16'h0000, expw[t * 6 + d]});
            end
         end
      end
      wr(4'h0, 32'h0000_270F);
      out_freq <= 16'h0123;
      tick(4);
      chk16(panel_shown, 16'h0123);
      out_freq <= 16'h2710;
      tick(4);
      chk16(panel_shown, 16'hDDDD);
      wr(4'h6, 32'h0000_0001);
      out_freq <= 16'hFFF6;
      tick(4);
      chk16(lcd_shown, 16'hFFF6);
      chk16(panel_shown, 16'hDDDD);
      wr(4'h6, 32'h0000_0000);
      wr(4'h0, 32'h0000_2710);
      rdr(4'h0, rd);
      chk32(rd, 32'h0000_270F);
      wr(4'h1, 32'h0000_0047);
      wr(4'h8, 32'h0000_0002);
      wr(4'h8, 32'h0000_0000);
      pulses(1'b1, 6);
      tick(3);
      rdr(4'h9, rd);
      chk32(rd, 32'h0000_0003);
      chk16(panel_shown, 16'h0003);
      cumulative_clear_input <= 1'b1;
      tick(3);
      pulses(1'b1, 2);
      cumulative_clear_input <= 1'b0;
      tick(3);
      chk16(cum_value, 16'h0001);
      wr(4'h7, 32'h0000_0001);
      cumulative_clear_input <= 1'b1;
      pulses(1'b1, 4);
      tick(2);
      chk16(cum_value, 16'h0000);
      cumulative_clear_input <= 1'b0;
      wr(4'h8, 32'h0000_0001);
      pulses(1'b0, 5);
      tick(3);
      wr(4'h9, 32'h0000_1234);
      wr(4'h3, 32'h0000_0047);
      rdr(4'h9, rd);
      chk32(rd, 32'hFFFF_FFFB);
      chk16(lcd_shown, 16'hFFFB);
      chk16(panel_shown, 16'hDDDD);
      chk32(mon_value[1], 32'hFFFF_FFFB);
      pulses(1'b1, 32773);
      tick(3);
      chk16(cum_value, 16'h0000);
      chk16(cum_overflow, 16'h0001);
      wr(4'h1, 32'h0000_0048);
      tick(4);
      chk16(panel_shown, 16'h0001);
      rdr(4'hA, rd);
      chk32(rd, 32'h0000_0001);
      wr(4'h2, 32'h0000_0048);
      wr(4'h4, 32'h0000_0048);
      wr(4'h5, 32'h0000_001A);
      tick(2);
      chk32(mon_value[0], 32'h0000_0001);
      chk32(mon_value[2], 32'h0000_0001);
      chk32(mon_value[3], 32'h0000_0924);
      servo_on <= 1'b0;
      tick(2);
      servo_on <= 1'b1;
      pulse_delta[0] <= 16'hFFFF;
      tick(1);
      pulse_delta[0] <= 16'h0001;
      tick(1);
      pulse_delta[0] <= 16'h0000;
      tick(4);
      chk32(mon_value[3], 32'h0000_0000);
      give_verdict();
   end
endmodule
